/* rtl/rqh_rx_queue.sv */
// receive queue with host register access, dma readout and threshold interrupt
`timescale 1ns/1ns
// Notes on behaviour
// - control one: bit 10 flow control, bit 0 block
// - checksum and address filter config exported
// - read-only header status of head frame
// - read-only 12-bit byte count of head frame
// - dma bit routes data register to queue
// - auto-dequeue frame once fully read
// - optional two-byte offset before ip header
// - pointer auto-increments on data accesses
// - dwell time over threshold raises interrupt
// - queued bytes over threshold raises interrupt
// - queued frames over threshold raises interrupt
// - interrupt output gated by enable bit 13
// - status bits clear on write of one
// - frame total snapshot in upper byte
// - first dma read returns dummy item
// - clearing receive status refreshes frame total
// - reading frame total loads head header
// - reading both header registers loads next header
// - frame: status, count, data from offset four
module rqh_rx_queue
  import rqh_pkg::*;
#(
  parameter int AW = 11
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // host bus
  input wire rqh_bus_req_t bus_req_i,
  output logic [15:0] bus_rdata_o,
  output logic bus_rvalid_o,
  // receive frame stream
  input wire rqh_rx_word_t rx_word_i,
  output logic rx_ready_o,
  // receive configuration to the mac
  output logic rx_flow_ctl_en_o,
  output logic rx_block_mode_o,
  output logic [15:0] rx_ctl_one_o,
  output logic [15:0] rx_ctl_two_o,
  // interrupt to host
  output logic rx_irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // merge write data into a register by byte lane
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // words a frame occupies: header plus data padded to a double word
  function automatic logic [AW-1:0] frame_words(input logic [11:0] bc);
    logic [12:0] c;
    c = {1'b0, bc} + 13'h0003;
    c[1:0] = 2'b00;
    frame_words = AW'(c >> 1) + AW'(2);
  endfunction : frame_words

  ////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [15:0] mem [2**AW];            // queue words
  logic [AW-1:0] wr_ptr_q;             // next word to write
  logic [AW-1:0] fr_start_q;           // start of frame being written
  logic [11:0] wr_bc_q;                // byte count of frame being written
  logic wr_idx1_q;                     // next word is the count word
  logic [AW-1:0] rd_base_q;            // head frame start
  logic [AW-1:0] hdr_ptr_q;            // frame shown in header registers
  logic [7:0] frames_q;                // committed frames
  logic [15:0] bytes_q;                // committed bytes
  logic [15:0] rc1_q, rc2_q, rdp_q, dtt_q, dbct_q, ier_q, fct_q, qc_rw_q;
  logic [15:0] hs_q, bc_q;             // header registers
  logic hs_seen_q, bc_seen_q;          // header reads since last load
  logic isr_rx_q;                      // sticky receive status
  logic [7:0] rx_queued_frame_total_q;                  // frame total snapshot
  logic dummy_q;                       // next dma read is a dummy
  logic [15:0] dwell_q;                // head frame age in us
  logic [$clog2(RQH_TICK_CYC+1)-1:0] tick_q;
  logic [15:0] rdata_q;
  logic rvalid_q;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire acc_w = bus_req_i.cs;
  wire rd_w = acc_w & bus_req_i.rd;
  wire wr_w = acc_w & bus_req_i.wr;
  wire [11:0] a_w = bus_req_i.addr;
  wire dma_w = qc_rw_q[RQH_QC_DMA];
  wire data_rd_w = rd_w & (a_w == RQH_OFF_DATA) & dma_w;
  wire real_rd_w = data_rd_w & ~dummy_q;
  wire wide_w = &bus_req_i.be;
  wire isr_clr_w = wr_w & (a_w == RQH_OFF_ISR) & bus_req_i.wdata[RQH_IRQ_RX] & bus_req_i.be[1];

  ////////////////////////////////////////////////////////////////////////
  // receive write side
  wire full_w = (wr_ptr_q + AW'(1)) == rd_base_q;
  assign rx_ready_o = ~full_w;
  wire push_w = rx_word_i.valid & ~full_w;
  wire commit_w = push_w & rx_word_i.last;
  wire [11:0] push_bc_w = wr_idx1_q ? rx_word_i.word[11:0] : wr_bc_q;

  ////////////////////////////////////////////////////////////////////////
  // head frame and dma address
  wire [11:0] head_bc_w = mem[rd_base_q + AW'(1)][11:0];
  wire [12:0] ptr_w = {2'b00, rdp_q[10:0]};
  wire ofs_w = qc_rw_q[RQH_QC_OFS];
  wire in_gap_w = ofs_w & (ptr_w >= RQH_HDR_BYTES) & (ptr_w < RQH_HDR_BYTES + RQH_IPOFS_BYTES);
  wire [12:0] eff_w = (ofs_w & (ptr_w >= RQH_HDR_BYTES)) ? ptr_w - RQH_IPOFS_BYTES : ptr_w;
  wire [15:0] qword_w = mem[rd_base_q + AW'(eff_w >> 1)];
  wire [7:0] qbyte_w = eff_w[0] ? qword_w[15:8] : qword_w[7:0];
  wire [15:0] dma_data_w = in_gap_w ? RQH_RST_VAL : (wide_w ? qword_w : {qbyte_w, qbyte_w});
  wire [12:0] step_w = wide_w ? 13'h0002 : 13'h0001;
  wire [12:0] ptr_next_w = ptr_w + step_w;
  wire [12:0] pad_w = {1'b0, head_bc_w} + (ofs_w ? RQH_IPOFS_BYTES : 13'h0000) + 13'h0003;
  wire [12:0] end_w = RQH_HDR_BYTES + {pad_w[12:2], 2'b00};
  wire deq_w = real_rd_w & qc_rw_q[RQH_QC_ADQ] & (frames_q != 8'h00) & (ptr_next_w >= end_w);

  ////////////////////////////////////////////////////////////////////////
  // occupancy
  wire [7:0] frames_d = frames_q + (commit_w ? 8'h01 : 8'h00) - (deq_w ? 8'h01 : 8'h00);
  wire [15:0] bytes_d = bytes_q + (commit_w ? {4'h0, push_bc_w} : 16'h0000) - (deq_w ? {4'h0, head_bc_w} : 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // threshold conditions
  wire f_hit_w = qc_rw_q[RQH_QC_FEN] & (frames_q > fct_q[7:0]);
  wire b_hit_w = qc_rw_q[RQH_QC_BEN] & (bytes_q > dbct_q);
  wire t_hit_w = qc_rw_q[RQH_QC_TEN] & (dwell_q > dtt_q);
  wire rx_evt_w = f_hit_w | b_hit_w | t_hit_w;
  wire tick_w = tick_q == ($bits(tick_q))'(RQH_TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // header load
  wire [AW-1:0] hdr_next_w = hdr_ptr_q + frame_words(bc_q[11:0]);
  // an empty queue has no head header, so a total read then loads nothing
  wire rx_queued_frame_total_rd_w = rd_w & (a_w == RQH_OFF_RX_QUEUED_FRAME_TOTAL);
  wire ld_head_w = rx_queued_frame_total_rd_w & (frames_q != 8'h00);
  wire hs_rd_w = rd_w & (a_w == RQH_OFF_HS);
  wire bc_rd_w = rd_w & (a_w == RQH_OFF_BC);
  wire ld_next_w = ~rx_queued_frame_total_rd_w & (hs_seen_q | hs_rd_w) & (bc_seen_q | bc_rd_w);
  wire [AW-1:0] hdr_src_w = ld_head_w ? rd_base_q : hdr_next_w;

  ////////////////////////////////////////////////////////////////////////
  // register read mux
  wire [15:0] qc_view_w = qc_rw_q | {3'b000, t_hit_w, b_hit_w, f_hit_w, 10'h000};
  logic [15:0] rmux_w;
  always_comb begin
    case (a_w)
      RQH_OFF_RC1: rmux_w = rc1_q;
      RQH_OFF_RC2: rmux_w = rc2_q;
      RQH_OFF_HS: rmux_w = hs_q;
      RQH_OFF_BC: rmux_w = {4'h0, bc_q[11:0]};
      RQH_OFF_QCTL: rmux_w = qc_view_w;
      RQH_OFF_RDP: rmux_w = rdp_q;
      RQH_OFF_DTT: rmux_w = dtt_q;
      RQH_OFF_DBCT: rmux_w = dbct_q;
      RQH_OFF_IER: rmux_w = ier_q;
      RQH_OFF_ISR: rmux_w = {2'b00, isr_rx_q, 13'h0000};
      RQH_OFF_FCT: rmux_w = fct_q;
      RQH_OFF_RX_QUEUED_FRAME_TOTAL: rmux_w = {rx_queued_frame_total_q, 8'h00};
      RQH_OFF_DATA: rmux_w = (dma_w & ~dummy_q) ? dma_data_w : RQH_RST_VAL;
      default: rmux_w = RQH_RST_VAL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // queue memory write, no reset on the array
  always_ff @(posedge core_clk_i) begin
    if (push_w) begin
      mem[wr_ptr_q] <= rx_word_i.word;
    end
  end

  // write pointer and frame commit
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      fr_start_q <= '0;
      wr_bc_q <= '0;
      wr_idx1_q <= 1'b0;
    end else if (commit_w) begin
      wr_ptr_q <= fr_start_q + frame_words(push_bc_w);
      fr_start_q <= fr_start_q + frame_words(push_bc_w);
      wr_idx1_q <= 1'b0;
    end else if (push_w) begin
      wr_ptr_q <= wr_ptr_q + AW'(1);
      wr_bc_q <= push_bc_w;
      wr_idx1_q <= (wr_ptr_q == fr_start_q);
    end
  end

  // occupancy and head pointer
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      frames_q <= '0;
      bytes_q <= '0;
      rd_base_q <= '0;
    end else begin
      frames_q <= frames_d;
      bytes_q <= bytes_d;
      if (deq_w) begin
        rd_base_q <= rd_base_q + frame_words(head_bc_w);
      end
    end
  end

  // dwell timer in us steps, restarts per head frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || deq_w || frames_q == 8'h00) begin
      tick_q <= '0;
      dwell_q <= '0;
    end else begin
      tick_q <= tick_w ? '0 : tick_q + ($bits(tick_q))'(1);
      if (tick_w && dwell_q != 16'hFFFF) begin
        dwell_q <= dwell_q + 16'h0001;
      end
    end
  end

  // host-written registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rc1_q <= RQH_RST_VAL;
      rc2_q <= RQH_RST_VAL;
      dtt_q <= RQH_RST_VAL;
      dbct_q <= RQH_RST_VAL;
      ier_q <= RQH_RST_VAL;
      fct_q <= RQH_RST_VAL;
      qc_rw_q <= RQH_RST_VAL;
    end else if (wr_w) begin
      case (a_w)
        RQH_OFF_RC1: rc1_q <= merge16(rc1_q, bus_req_i.wdata, bus_req_i.be);
        RQH_OFF_RC2: rc2_q <= merge16(rc2_q, bus_req_i.wdata, bus_req_i.be);
        RQH_OFF_DTT: dtt_q <= merge16(dtt_q, bus_req_i.wdata, bus_req_i.be);
        RQH_OFF_DBCT: dbct_q <= merge16(dbct_q, bus_req_i.wdata, bus_req_i.be);
        RQH_OFF_IER: ier_q <= merge16(ier_q, bus_req_i.wdata, bus_req_i.be);
        RQH_OFF_FCT: fct_q <= merge16(fct_q, bus_req_i.wdata, bus_req_i.be) & 16'h00FF;
        RQH_OFF_QCTL: qc_rw_q <= merge16(qc_rw_q, bus_req_i.wdata, bus_req_i.be) & RQH_QC_RW_MASK;
        default: qc_rw_q <= qc_rw_q;
      endcase
    end
  end

  // data pointer: host write, auto-increment, reset on dequeue
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdp_q <= RQH_RST_VAL;
    end else if (wr_w && a_w == RQH_OFF_RDP) begin
      rdp_q <= merge16(rdp_q, bus_req_i.wdata, bus_req_i.be) & RQH_RDP_MASK;
    end else if (deq_w) begin
      rdp_q[10:0] <= '0;
    end else if (real_rd_w && rdp_q[RQH_RDP_AINC]) begin
      rdp_q[10:0] <= ptr_next_w[10:0];
    end
  end

  // dummy flag armed when dma access starts
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dummy_q <= 1'b0;
    end else if (wr_w && a_w == RQH_OFF_QCTL && bus_req_i.be[0] && bus_req_i.wdata[RQH_QC_DMA] && !dma_w) begin
      dummy_q <= 1'b1;
    end else if (data_rd_w) begin
      dummy_q <= 1'b0;
    end
  end

  // sticky receive status, set wins over clear; frame total snapshot
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      isr_rx_q <= 1'b0;
      rx_queued_frame_total_q <= '0;
    end else begin
      isr_rx_q <= rx_evt_w | (isr_rx_q & ~isr_clr_w);
      if (isr_clr_w) begin
        rx_queued_frame_total_q <= frames_q;
      end
    end
  end

  // header registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hs_q <= RQH_RST_VAL;
      bc_q <= RQH_RST_VAL;
      hdr_ptr_q <= '0;
      hs_seen_q <= 1'b0;
      bc_seen_q <= 1'b0;
    end else if (ld_head_w || ld_next_w) begin
      hs_q <= mem[hdr_src_w];
      bc_q <= {4'h0, mem[hdr_src_w + AW'(1)][11:0]};
      hdr_ptr_q <= hdr_src_w;
      hs_seen_q <= 1'b0;
      bc_seen_q <= 1'b0;
    end else begin
      hs_seen_q <= hs_seen_q | hs_rd_w;
      bc_seen_q <= bc_seen_q | bc_rd_w;
    end
  end

  // read data register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= RQH_RST_VAL;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_w;
      if (rd_w) begin
        rdata_q <= rmux_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus_rdata_o = rdata_q;
  assign bus_rvalid_o = rvalid_q;
  assign rx_flow_ctl_en_o = rc1_q[RQH_RC1_FLOW];
  assign rx_block_mode_o = rc1_q[RQH_RC1_BLOCK];
  assign rx_ctl_one_o = rc1_q;
  assign rx_ctl_two_o = rc2_q;
  assign rx_irq_o = isr_rx_q & ier_q[RQH_IRQ_RX];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // dma start arms the dummy; the first data read after it is the dummy
  sequence s_dma_start;
    wr_w && a_w == RQH_OFF_QCTL && bus_req_i.be[0] && bus_req_i.wdata[RQH_QC_DMA] && !dma_w;
  endsequence
  sequence s_dummy_read;
    data_rd_w && dummy_q;
  endsequence
  // a real data read that falls in the two-byte ip offset gap
  sequence s_gap_read;
    real_rd_w && in_gap_w;
  endsequence

  // interrupt status and gating
  irq_gate_a: assert property (!ier_q[RQH_IRQ_RX] |-> !rx_irq_o) else $error("irq without enable");
  status_sticky_a: assert property (isr_rx_q && !isr_clr_w |=> isr_rx_q) else $error("status lost");
  status_clear_a: assert property (isr_clr_w && !rx_evt_w |=> !isr_rx_q) else $error("w1c failed");
  // thresholds: sticky interrupt status one edge later; the frame check also covers live status at once
  frame_thr_a: assert property (qc_rw_q[RQH_QC_FEN] && frames_q > fct_q[7:0]
    |-> qc_view_w[RQH_QC_FST] ##1 isr_rx_q) else $error("frame threshold");
  byte_thr_a: assert property (qc_rw_q[RQH_QC_BEN] && bytes_q > dbct_q |=> isr_rx_q) else $error("byte threshold");
  dwell_thr_a: assert property (qc_rw_q[RQH_QC_TEN] && dwell_q > dtt_q |=> isr_rx_q) else $error("dwell threshold");
  total_snap_a: assert property (isr_clr_w |=> rx_queued_frame_total_q == $past(frames_q)) else $error("total not refreshed");

  // dma readout: dummy first, zero gap, no data without the dma bit
  dummy_read_a: assert property (s_dummy_read |=> rdata_q == RQH_RST_VAL && $stable(rdp_q))
    else $error("dummy read missing");
  dma_arm_a: assert property (s_dma_start |=> dummy_q) else $error("dummy not armed");
  gap_read_a: assert property (s_gap_read |=> rdata_q == RQH_RST_VAL) else $error("offset gap not zero");
  data_gate_a: assert property (rd_w && a_w == RQH_OFF_DATA && !dma_w |=> rdata_q == RQH_RST_VAL)
    else $error("data read without dma");
  // a dequeue drops one frame and rewinds the byte pointer
  dequeue_a: assert property (deq_w && !commit_w
    |=> frames_q == $past(frames_q) - 8'h01 && rdp_q[10:0] == 11'h000) else $error("dequeue wrong");

  // header loading and pointer stepping
  head_load_a: assert property (ld_head_w |=> hs_q == $past(mem[rd_base_q]) && hdr_ptr_q == $past(rd_base_q))
    else $error("head header not loaded");
  next_load_a: assert property (ld_next_w |=> hdr_ptr_q == $past(hdr_next_w))
    else $error("next header not loaded");
  auto_inc_a: assert property (real_rd_w && rdp_q[RQH_RDP_AINC] && !deq_w && !(wr_w && a_w == RQH_OFF_RDP)
    |=> rdp_q[10:0] == $past(ptr_next_w[10:0])) else $error("pointer not advanced");

endmodule : rqh_rx_queue

/* rtl/rqh_pkg.sv */
// constants, field layout and bus carriers for the receive-queue host readout
package rqh_pkg;
  // register offsets on the host bus
  localparam logic [11:0] RQH_OFF_RC1 = 12'h174;
  localparam logic [11:0] RQH_OFF_RC2 = 12'h176;
  localparam logic [11:0] RQH_OFF_HS = 12'h17C;
  localparam logic [11:0] RQH_OFF_BC = 12'h17E;
  localparam logic [11:0] RQH_OFF_QCTL = 12'h182;
  localparam logic [11:0] RQH_OFF_RDP = 12'h186;
  localparam logic [11:0] RQH_OFF_DTT = 12'h18C;
  localparam logic [11:0] RQH_OFF_DBCT = 12'h18E;
  localparam logic [11:0] RQH_OFF_IER = 12'h190;
  localparam logic [11:0] RQH_OFF_ISR = 12'h192;
  localparam logic [11:0] RQH_OFF_FCT = 12'h19C;
  localparam logic [11:0] RQH_OFF_RX_QUEUED_FRAME_TOTAL = 12'h1B8;
  localparam logic [11:0] RQH_OFF_DATA = 12'h1C0;
  // field positions
  localparam int RQH_RC1_FLOW = 10;
  localparam int RQH_RC1_BLOCK = 0;
  localparam int RQH_QC_DMA = 3;
  localparam int RQH_QC_ADQ = 4;
  localparam int RQH_QC_FEN = 5;
  localparam int RQH_QC_BEN = 6;
  localparam int RQH_QC_TEN = 7;
  localparam int RQH_QC_OFS = 9;
  localparam int RQH_QC_FST = 10;
  localparam int RQH_QC_BST = 11;
  localparam int RQH_QC_TST = 12;
  localparam int RQH_RDP_AINC = 14;
  localparam int RQH_IRQ_RX = 13;
  // writable masks and reset value
  localparam logic [15:0] RQH_QC_RW_MASK = 16'h02F8;
  localparam logic [15:0] RQH_RDP_MASK = 16'h47FF;
  localparam logic [15:0] RQH_RST_VAL = 16'h0000;
  // frame layout in bytes
  localparam logic [12:0] RQH_HDR_BYTES = 13'h0004;
  localparam logic [12:0] RQH_IPOFS_BYTES = 13'h0002;
  localparam int RQH_MAX_FRAME = 2000;
  // timing: dwell counted in 1 us steps
  localparam int RQH_CLK_NS = 100;
  localparam int RQH_TICK_NS = 1000;
  localparam int RQH_TICK_CYC = (RQH_TICK_NS / RQH_CLK_NS < 1) ? 1 : RQH_TICK_NS / RQH_CLK_NS;
  // host bus request, one cycle per access
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } rqh_bus_req_t;
  // frame word stream from the receive mac
  typedef struct packed {
    logic valid;
    logic last;
    logic [15:0] word;
  } rqh_rx_word_t;
endpackage : rqh_pkg

/* dv/rqh_host_model.sv */
// host processor model: register cycles and dma frame readout on the host bus
`timescale 1ns/1ns
module rqh_host_model
  import rqh_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // host bus towards the device
  output rqh_bus_req_t bus_req_o,
  input wire logic [15:0] bus_rdata_i,
  input wire logic bus_rvalid_i
);
  // bus idle at time zero
  initial bus_req_o = '0;
  ////////////////////////////////////////////////////////////////
  // one 16-bit write, a one-cycle pulse launched on the falling edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    bus_req_o = {3'b101, a, 2'h3, d};
    @(negedge core_clk_i);
    // released lines show the inverse, not the last value
    bus_req_o = {3'b000, ~a, 2'h0, ~d};
  endtask : wr
  // one read on the given lanes, data taken when the answer pulse is seen
  task automatic rd_be(input logic [11:0] a, input logic [1:0] be, output logic [15:0] d);
    int n;
    d = 16'hXXXX;
    @(negedge core_clk_i);
    bus_req_o = {3'b110, a, be, 16'h0000};
    @(negedge core_clk_i);
    bus_req_o = {3'b000, ~a, 2'h0, 16'hFFFF};
    for (n = 0; n < 4; n++) begin
      if (bus_rvalid_i === 1'b1) begin
        d = bus_rdata_i;
        break;
      end
      @(negedge core_clk_i);
    end
  endtask : rd_be
  // one 16-bit read
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    rd_be(a, 2'h3, d);
  endtask : rd
  // clear every pending status bit after an interrupt
  task automatic clr_all();
    wr(RQH_OFF_ISR, 16'hFFFF);
  endtask : clr_all
  // dma readout of one frame; w[0] is the dummy item the host discards
  task automatic rd_frame(input int nbytes, output logic [15:0] w[$]);
    logic [15:0] d;
    w = {};
    rd(RQH_OFF_DATA, d);
    w.push_back(d);
    // reads run on to the double-word boundary of the data, with no allowance for the two-byte ip offset
    for (int i = 0; i < 2 + ((nbytes + 3) / 4) * 2; i++) begin
      rd(RQH_OFF_DATA, d);
      w.push_back(d);
    end
  endtask : rd_frame
endmodule : rqh_host_model

/* dv/rx_queue_host_readout_test.sv */
// self-checking bench for the receive-queue host readout
`timescale 1ns/1ns
module rx_queue_host_readout_test
  import rqh_pkg::*;
;
  // clock, reset and design signals
  logic core_clk_i;
  logic rst_n_i;
  rqh_bus_req_t bus_req;
  logic [15:0] rdata;
  logic rvalid;
  rqh_rx_word_t rx_word;
  logic rx_ready, flow, blk, irq;
  logic [15:0] ctl1, ctl2;
  int bad_count, n_compared;
  ////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial core_clk_i = 1'b0;
  always #50 core_clk_i = ~core_clk_i;
  // host partner model
  rqh_host_model host (.core_clk_i(core_clk_i), .bus_req_o(bus_req), .bus_rdata_i(rdata), .bus_rvalid_i(rvalid));
  // device under test
  rqh_rx_queue #(.AW(11)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req), .bus_rdata_o(rdata),
    .bus_rvalid_o(rvalid), .rx_word_i(rx_word), .rx_ready_o(rx_ready), .rx_flow_ctl_en_o(flow),
    .rx_block_mode_o(blk), .rx_ctl_one_o(ctl1), .rx_ctl_two_o(ctl2), .rx_irq_o(irq));
  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // read a register and compare
  task automatic rdchk(input logic [11:0] a, input logic [15:0] exp, input string msg);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp, msg);
  endtask : rdchk
  // push one frame from the mac side: status, count, data words
  task automatic push(input logic [15:0] st, input logic [15:0] bc, input logic [15:0] dw[$]);
    logic [15:0] wl[$];
    wl = {st, bc};
    foreach (dw[i]) wl.push_back(dw[i]);
    foreach (wl[i]) begin
      @(negedge core_clk_i);
      rx_word = {1'b1, (i == wl.size() - 1), wl[i]};
    end
    @(negedge core_clk_i);
    rx_word = {2'b00, 16'hFFFF};
    @(negedge core_clk_i);
  endtask : push
  ////////////////////////////////////////////////////////////////
  // reset state and an unmapped read
  task automatic t_reset();
    chk(irq, 1'b0, "irq after reset");
    chk(rx_ready, 1'b1, "ready after reset");
    rdchk(RQH_OFF_QCTL, 16'h0000, "queue control reset");
    rdchk(12'h100, 16'h0000, "unmapped read");
  endtask : t_reset
  // receive control registers and their outputs
  task automatic t_ctl();
    host.wr(RQH_OFF_RC1, 16'h0401);
    host.wr(RQH_OFF_RC2, 16'h00A5);
    chk(flow, 1'b1, "flow control on");
    chk(blk, 1'b1, "block mode on");
    chk(ctl2, 16'h00A5, "control two out");
    rdchk(RQH_OFF_RC1, 16'h0401, "control one readback");
    host.wr(RQH_OFF_RC1, 16'h0400);
    chk(blk, 1'b0, "block mode off");
    chk(ctl1, 16'h0400, "control one out");
  endtask : t_ctl
  // frame threshold, enable, sticky status, total and header loading
  task automatic t_irq();
    host.wr(RQH_OFF_FCT, 16'h0001);
    host.wr(RQH_OFF_QCTL, 16'h0020);
    push(16'hA5A5, 16'h0005, {16'h1111, 16'h2222, 16'h3333, 16'h4444});
    rdchk(RQH_OFF_QCTL, 16'h0020, "one frame at threshold");
    push(16'h1234, 16'h0002, {16'hBEEF, 16'h0000});
    rdchk(RQH_OFF_QCTL, 16'h0420, "frame threshold status");
    chk(irq, 1'b0, "irq masked");
    host.wr(RQH_OFF_IER, 16'h2000);
    chk(irq, 1'b1, "irq enabled");
    host.wr(RQH_OFF_QCTL, 16'h0000);
    chk(irq, 1'b1, "irq held");
    rdchk(RQH_OFF_ISR, 16'h2000, "status held");
    host.clr_all();
    chk(irq, 1'b0, "irq cleared");
    rdchk(RQH_OFF_RX_QUEUED_FRAME_TOTAL, 16'h0200, "frame total");
    rdchk(RQH_OFF_HS, 16'hA5A5, "head status");
    rdchk(RQH_OFF_BC, 16'h0005, "head count");
    rdchk(RQH_OFF_HS, 16'h1234, "next status");
    rdchk(RQH_OFF_BC, 16'h0002, "next count");
  endtask : t_irq
  // dma readout, auto-dequeue and the ip offset
  task automatic t_dma();
    logic [15:0] w[$];
    host.wr(RQH_OFF_QCTL, 16'h0018);
    host.wr(RQH_OFF_RDP, 16'h4000);
    host.rd_frame(5, w);
    chk(w[0], 16'h0000, "dummy item");
    chk(w[1], 16'hA5A5, "status word");
    chk(w[2], 16'h0005, "count word");
    for (int i = 0; i < 4; i++) chk(w[3 + i], 16'(16'h1111 * (i + 1)), "data word");
    rdchk(RQH_OFF_RDP, 16'h4000, "pointer rewound");
    host.clr_all();
    rdchk(RQH_OFF_RX_QUEUED_FRAME_TOTAL, 16'h0100, "one frame left");
    host.wr(RQH_OFF_QCTL, 16'h0000);
    rdchk(RQH_OFF_DATA, 16'h0000, "data without dma");
    host.wr(RQH_OFF_QCTL, 16'h0218);
    host.rd_frame(4, w);
    chk(w[0], 16'h0000, "dummy again");
    chk(w[1], 16'h1234, "second status");
    chk(w[2], 16'h0002, "second count");
    chk(w[3], 16'h0000, "offset gap");
    chk(w[4], 16'hBEEF, "shifted data");
    host.clr_all();
    rdchk(RQH_OFF_RX_QUEUED_FRAME_TOTAL, 16'h0000, "queue empty");
  endtask : t_dma
  // byte threshold at and above its boundary, then an 8-bit dma readout
  task automatic t_bytes();
    logic [15:0] d;
    host.wr(RQH_OFF_DBCT, 16'h0003);
    host.wr(RQH_OFF_QCTL, 16'h0040);
    push(16'h0F0F, 16'h0004, {16'h5555, 16'h6666});
    rdchk(RQH_OFF_QCTL, 16'h0840, "byte threshold over");
    chk(irq, 1'b1, "byte irq");
    host.wr(RQH_OFF_DBCT, 16'h0004);
    rdchk(RQH_OFF_QCTL, 16'h0040, "byte threshold equal");
    host.clr_all();
    // byte reads: dummy byte first, one pointer step per byte
    host.wr(RQH_OFF_QCTL, 16'h0008);
    host.wr(RQH_OFF_RDP, 16'h4000);
    host.rd_be(RQH_OFF_DATA, 2'h1, d);
    chk(d, 16'h0000, "byte dummy");
    host.rd_be(RQH_OFF_DATA, 2'h1, d);
    chk(d, 16'h0F0F, "status low byte");
    host.rd_be(RQH_OFF_DATA, 2'h1, d);
    chk(d, 16'h0F0F, "status high byte");
    host.rd_be(RQH_OFF_DATA, 2'h1, d);
    chk(d, 16'h0404, "count low byte");
    host.rd_be(RQH_OFF_DATA, 2'h1, d);
    chk(d, 16'h0000, "count high byte");
    rdchk(RQH_OFF_RDP, 16'h4004, "byte steps");
  endtask : t_bytes
  // dwell timer threshold
  task automatic t_dwell();
    host.wr(RQH_OFF_DTT, 16'hFFFF);
    host.wr(RQH_OFF_QCTL, 16'h0080);
    rdchk(RQH_OFF_QCTL, 16'h0080, "dwell below");
    host.wr(RQH_OFF_DTT, 16'h0002);
    repeat (40) @(negedge core_clk_i);
    rdchk(RQH_OFF_QCTL, 16'h1080, "dwell over");
    chk(irq, 1'b1, "dwell irq");
  endtask : t_dwell
  ////////////////////////////////////////////////////////////////
  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    rx_word = '0;
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_ctl();
    t_irq();
    t_dma();
    t_bytes();
    t_dwell();
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule : rx_queue_host_readout_test
